// file: rtl/pwc_regs.svh
// register offsets, reset values, clock select codes and channel counts of the pwm channel core
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_OFS_ENABLE   8'h00
`define PWC_OFS_POLARITY 8'h01
`define PWC_OFS_CSEL_LO  8'h02
`define PWC_OFS_CSEL_HI  8'h03
`define PWC_OFS_ALIGN    8'h04
`define PWC_OFS_JOIN     8'h05
`define PWC_OFS_COUNTER  8'h08
`define PWC_OFS_PERIOD   8'h10
`define PWC_OFS_DUTY     8'h18

`define PWC_RST_BYTE     8'h00
`define PWC_RST_CSEL     16'hA0A0
`define PWC_RST_JOIN     4'h0
`define PWC_RST_WIDE     16'h0000

`define PWC_TICK_A       2'h0
`define PWC_TICK_SA      2'h1
`define PWC_TICK_B       2'h2
`define PWC_TICK_SB      2'h3

`define PWC_NUM_CH       8
`define PWC_NUM_PAIR     4

`endif

// file: rtl/pwc_pkg.sv
// types shared by the pwm channel core
package pwc_pkg;

  typedef enum logic {
    PWC_UP,
    PWC_DOWN
  } pwc_dir_e;

  // next state of one channel, 16 bits wide for joined pairs
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] dty;
    pwc_dir_e    dir;
    logic        ff;
  } pwc_chst_s;

  typedef logic [7:0] pwc_byte_t;

endpackage

// file: rtl/pwc_core.sv
// eight-channel pwm waveform core with pair joining and byte register port
//
// Operation
// [RULE1] align bit 0 left, 1 center
// [RULE2] left mode counter counts up only
// [RULE3] duty match toggles output flip-flop
// [RULE4] left period match resets, loads buffers
// [RULE5] left counter runs zero to period minus one
// [RULE6] polarity picks high or low duty share
// [RULE7] center mode up/down, up at zero
// [RULE8] center period match turns count down
// [RULE9] center down duty match toggles again
// [RULE10] center zero turns up, loads buffers
// [RULE11] center effective period is twice period
// [RULE12] four join bits merge pairs to 16-bit
// [RULE13] software joins only disabled pairs
// [RULE14] even channel holds upper bytes
// [RULE15] odd channel clock, polarity, output rule
// [RULE16] odd enable rules pair, even output off
// [RULE17] any counter byte write clears pair
// [RULE18] software reads joined counter coherently
// [RULE19] odd align bit sets pair mode
// [RULE20] fixed outputs on boundary values
// [RULE21] zero period holds counter at zero
// [RULE22] software sets alignment before enabling
// [RULE23] enabled writes buffered, disabled immediate
//
// register map, one byte each
//   00 channel enables, bit n for channel n
//   01 start polarity, 1 starts high
//   02 clock select channels 0-3, two bits each
//   03 clock select channels 4-7, two bits each
//   04 alignment, 1 selects center mode
//   05 pair join bits, bit 0 pairs channels 0/1
//   06-07 unmapped, read as zero
//   08-0F channel counters, any write clears
//   10-17 period buffers, read back as written
//   18-1F duty buffers, read back as written
//
// clock select codes
//   0 tick a, 1 tick sa, 2 tick b, 3 tick sb
//   reset picks a for 0,1,4,5 and b for 2,3,6,7
//
// read port
//   data one cycle after the strobe, else zero
//   high counter byte of a pair freezes low byte
//   low byte read of a pair returns frozen copy
//
// timing
//   counter steps on a selected tick only
//   waveform registers on the same clock as the counter
//   disabled channels drive a low output
//   even channel of a joined pair stays low
//
// hazards
//   join bits only while the pair is disabled
//   alignment change while running may glitch
//   period zero parks the counter at zero
//   period and duty buffered while enabled
//   counter write loads buffers at once
//
// joined pairs
//   odd engine runs sixteen bits wide
//   even counter, period, duty form upper bytes
//   odd enable, polarity, clock, alignment rule
//   output appears on the odd channel only
//
// The strobed register port and the register offsets were decided locally.
`include "pwc_regs.svh"

module pwc_core
  import pwc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [3:0] clk_tick,
  output logic      [7:0] channel_waveform_output
);

  // true when the address falls in an eight-entry per-channel block
  function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
    in_blk = (a[7:3] == base[7:3]);
  endfunction

  pwc_byte_t   channel_enable_bit;
  pwc_byte_t   channel_start_polarity;
  pwc_byte_t   align_mode_control_reg;
  logic [3:0]  pair_join_control_reg;
  logic [15:0] channel_clock_select;
  pwc_byte_t   cnt_r   [`PWC_NUM_CH];
  pwc_byte_t   pbuf_r  [`PWC_NUM_CH];
  pwc_byte_t   dbuf_r  [`PWC_NUM_CH];
  pwc_byte_t   pact_r  [`PWC_NUM_CH];
  pwc_byte_t   dact_r  [`PWC_NUM_CH];
  logic [7:0]  dir_r;
  logic [7:0]  ff_r;
  pwc_byte_t   latch_r;
  pwc_byte_t   rdata_r;
  logic [7:0]  out_r;
  pwc_chst_s   st_nxt  [`PWC_NUM_CH];
  logic [7:0]  out_nxt;
  logic [2:0]  ridx;

  assign ridx = reg_addr[2:0];
  assign reg_rdata = rdata_r;
  assign channel_waveform_output = out_r;

  // channel enables
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      channel_enable_bit <= `PWC_RST_BYTE;
    end else if (reg_wr && reg_addr == `PWC_OFS_ENABLE) begin
      channel_enable_bit <= reg_wdata;
    end
  end

  // start polarity
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      channel_start_polarity <= `PWC_RST_BYTE;
    end else if (reg_wr && reg_addr == `PWC_OFS_POLARITY) begin
      channel_start_polarity <= reg_wdata;
    end
  end

  // clock select, two bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      channel_clock_select <= `PWC_RST_CSEL;
    end else if (reg_wr && reg_addr == `PWC_OFS_CSEL_LO) begin
      channel_clock_select[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `PWC_OFS_CSEL_HI) begin
      channel_clock_select[15:8] <= reg_wdata;
    end
  end

  // alignment select
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      align_mode_control_reg <= `PWC_RST_BYTE;
    end else if (reg_wr && reg_addr == `PWC_OFS_ALIGN) begin
      align_mode_control_reg <= reg_wdata;
    end
  end

  // pair join bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pair_join_control_reg <= `PWC_RST_JOIN;
    end else if (reg_wr && reg_addr == `PWC_OFS_JOIN) begin
      pair_join_control_reg <= reg_wdata[3:0];                         // [RULE12]
    end
  end

  // period buffers, always written directly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        pbuf_r[k] <= `PWC_RST_BYTE;
      end
    end else if (reg_wr && in_blk(reg_addr, `PWC_OFS_PERIOD)) begin
      pbuf_r[ridx] <= reg_wdata;
    end
  end

  // duty buffers, always written directly
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        dbuf_r[k] <= `PWC_RST_BYTE;
      end
    end else if (reg_wr && in_blk(reg_addr, `PWC_OFS_DUTY)) begin
      dbuf_r[ridx] <= reg_wdata;
    end
  end

  // per-channel engines; an odd channel of a joined pair runs 16 bits wide
  for (genvar i = 0; i < `PWC_NUM_CH; i++) begin : g_ch
    localparam int  PEER = i ^ 1;
    localparam bit  ODD  = (i % 2) == 1;
    logic        jn;
    logic        wide;
    logic        en;
    logic        tk;
    logic        cwr;
    logic        pol;
    logic        dn;
    logic [15:0] c;
    logic [15:0] p;
    logic [15:0] d;
    logic [15:0] pb;
    logic [15:0] db;

    assign jn   = pair_join_control_reg[i/2];
    assign wide = jn && ODD;
    // even channel holds the upper bytes of a joined pair
    assign c  = wide ? {cnt_r[PEER], cnt_r[i]}   : {8'h00, cnt_r[i]};   // [RULE14]
    assign p  = wide ? {pact_r[PEER], pact_r[i]} : {8'h00, pact_r[i]};  // [RULE14]
    assign d  = wide ? {dact_r[PEER], dact_r[i]} : {8'h00, dact_r[i]};
    assign pb = wide ? {pbuf_r[PEER], pbuf_r[i]} : {8'h00, pbuf_r[i]};
    assign db = wide ? {dbuf_r[PEER], dbuf_r[i]} : {8'h00, dbuf_r[i]};
    assign en  = channel_enable_bit[i] && !(jn && !ODD);               // [RULE16]
    assign tk  = clk_tick[channel_clock_select[2*i +: 2]];             // [RULE15]
    assign pol = channel_start_polarity[i];                            // [RULE15]
    // a write to either counter byte of a pair clears the whole counter
    assign cwr = reg_wr && ((reg_addr == (`PWC_OFS_COUNTER + 8'(i))) ||
                 (wide && reg_addr == (`PWC_OFS_COUNTER + 8'(PEER)))); // [RULE17]
    assign dn  = (dir_r[i] == PWC_DOWN) && (c != 16'h0000);            // [RULE7]

    // counter, direction, flip-flop and active copies
    always_comb begin
      st_nxt[i].cnt = c;
      st_nxt[i].per = p;
      st_nxt[i].dty = d;
      st_nxt[i].dir = pwc_dir_e'(dir_r[i]);
      st_nxt[i].ff  = ff_r[i];
      if (cwr) begin
        st_nxt[i].cnt = 16'h0000;
        st_nxt[i].dir = PWC_UP;
        st_nxt[i].per = pb;
        st_nxt[i].dty = db;
        st_nxt[i].ff  = 1'b0;
      end else if (!en) begin
        st_nxt[i].per = pb;                                            // [RULE23]
        st_nxt[i].dty = db;                                            // [RULE23]
        if (tk && pb == 16'h0000) begin
          st_nxt[i].cnt = 16'h0000;
        end
      end else if (tk) begin
        if (p == 16'h0000) begin
          st_nxt[i].cnt = 16'h0000;                                    // [RULE21]
          st_nxt[i].dir = PWC_UP;
          st_nxt[i].ff  = 1'b0;
          st_nxt[i].per = pb;
          st_nxt[i].dty = db;
        end else if (!align_mode_control_reg[i]) begin                 // [RULE1] [RULE19]
          if (c >= p - 16'h0001) begin
            st_nxt[i].cnt = 16'h0000;                                  // [RULE4] [RULE5]
            st_nxt[i].ff  = 1'b0;                                      // [RULE4]
            st_nxt[i].per = pb;                                        // [RULE4] [RULE23]
            st_nxt[i].dty = db;                                        // [RULE4]
          end else begin
            st_nxt[i].cnt = c + 16'h0001;                              // [RULE2]
            if (c + 16'h0001 == d) begin
              st_nxt[i].ff = !ff_r[i];                                 // [RULE3]
            end
          end
          st_nxt[i].dir = PWC_UP;                                      // [RULE2]
        end else begin
          if (!dn && c < p) begin
            st_nxt[i].cnt = c + 16'h0001;                              // [RULE7]
            st_nxt[i].dir = PWC_UP;
          end else begin
            st_nxt[i].cnt = c - 16'h0001;                              // [RULE8] [RULE11]
            st_nxt[i].dir = PWC_DOWN;                                  // [RULE8]
          end
          if (st_nxt[i].cnt == 16'h0000 && st_nxt[i].dir == PWC_DOWN) begin
            st_nxt[i].dir = PWC_UP;                                    // [RULE10]
            st_nxt[i].per = pb;                                        // [RULE10] [RULE23]
            st_nxt[i].dty = db;                                        // [RULE10]
            st_nxt[i].ff  = 1'b0;
          end else if (st_nxt[i].cnt == d) begin
            st_nxt[i].ff = !ff_r[i];                                   // [RULE3] [RULE9]
          end
        end
      end
    end

    // output level from active values, boundary cases first
    always_comb begin
      if (!en) begin
        out_nxt[i] = 1'b0;                                             // [RULE16]
      end else if (st_nxt[i].per == 16'h0000) begin
        out_nxt[i] = pol;                                              // [RULE20]
      end else if (st_nxt[i].dty == 16'h0000) begin
        out_nxt[i] = !pol;                                             // [RULE20]
      end else if (st_nxt[i].dty >= st_nxt[i].per) begin
        out_nxt[i] = pol;                                              // [RULE20]
      end else begin
        out_nxt[i] = st_nxt[i].ff ^ pol;                               // [RULE6]
      end
    end
  end

  // counter and active copies; even bytes of a joined pair follow the odd engine
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        cnt_r[k]  <= `PWC_RST_BYTE;
        pact_r[k] <= `PWC_RST_BYTE;
        dact_r[k] <= `PWC_RST_BYTE;
      end
    end else begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        if (pair_join_control_reg[k/2] && (k % 2) == 0) begin
          cnt_r[k]  <= st_nxt[k | 1].cnt[15:8];                        // [RULE14]
          pact_r[k] <= st_nxt[k | 1].per[15:8];
          dact_r[k] <= st_nxt[k | 1].dty[15:8];
        end else begin
          cnt_r[k]  <= st_nxt[k].cnt[7:0];
          pact_r[k] <= st_nxt[k].per[7:0];
          dact_r[k] <= st_nxt[k].dty[7:0];
        end
      end
    end
  end

  // counting direction
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dir_r <= `PWC_RST_BYTE;
    end else begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        dir_r[k] <= st_nxt[k].dir;
      end
    end
  end

  // output flip-flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ff_r <= `PWC_RST_BYTE;
    end else begin
      for (int k = 0; k < `PWC_NUM_CH; k++) begin
        ff_r[k] <= st_nxt[k].ff;
      end
    end
  end

  // registered waveform
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_r <= `PWC_RST_BYTE;
    end else begin
      out_r <= out_nxt;
    end
  end

  // low byte of a joined counter, frozen when the high byte is read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_r <= `PWC_RST_BYTE;
    end else if (reg_rd && in_blk(reg_addr, `PWC_OFS_COUNTER) && !ridx[0]) begin
      latch_r <= cnt_r[ridx | 3'h1];                                   // [RULE18]
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= `PWC_RST_BYTE;
    end else if (reg_rd) begin
      rdata_r <= 8'h00;
      case (reg_addr)
        `PWC_OFS_ENABLE:   rdata_r <= channel_enable_bit;
        `PWC_OFS_POLARITY: rdata_r <= channel_start_polarity;
        `PWC_OFS_CSEL_LO:  rdata_r <= channel_clock_select[7:0];
        `PWC_OFS_CSEL_HI:  rdata_r <= channel_clock_select[15:8];
        `PWC_OFS_ALIGN:    rdata_r <= align_mode_control_reg;
        `PWC_OFS_JOIN:     rdata_r <= {4'h0, pair_join_control_reg};
        default: begin
          if (in_blk(reg_addr, `PWC_OFS_COUNTER)) begin
            if (pair_join_control_reg[ridx[2:1]] && ridx[0]) begin
              rdata_r <= latch_r;                                      // [RULE18]
            end else begin
              rdata_r <= cnt_r[ridx];
            end
          end else if (in_blk(reg_addr, `PWC_OFS_PERIOD)) begin
            rdata_r <= pbuf_r[ridx];
          end else if (in_blk(reg_addr, `PWC_OFS_DUTY)) begin
            rdata_r <= dbuf_r[ridx];
          end
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

endmodule // pwc_core

// file: dv/pwc_props.sv
// port-level assertions of the pwm channel core
module pwc_props
  import pwc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] clk_tick,
  input wire logic [7:0] channel_waveform_output
);
  logic [7:0] en_r;
  logic [7:0] en_q;
  logic [7:0] en_q2;
  logic [3:0] join_r;
  logic [3:0] join_q;
  logic [3:0] jn;
  logic [7:0] even_mask;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // mirrors of enable and join bytes, delayed to cover output lag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      en_r   <= 8'h00;
      join_r <= 4'h0;
    end else if (reg_wr && reg_addr == 8'h00) begin
      en_r <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h05) begin
      join_r <= reg_wdata[3:0];
    end
  end

  // delay stages
  always_ff @(posedge clk_sys) begin
    en_q   <= en_r;
    en_q2  <= en_q;
    join_q <= join_r;
  end

  // even channels of settled joined pairs
  assign jn        = join_r & join_q;
  assign even_mask = {1'b0, jn[3], 1'b0, jn[2], 1'b0, jn[1], 1'b0, jn[0]};

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_reset_out: assert property ($fell(reset) |-> channel_waveform_output == 8'h00) else $error("outputs set after reset");
  a_quiet_hold: assert property ((clk_tick == 4'h0 && !reg_wr)[*3] |=> $stable(channel_waveform_output))
    else $error("output moved without tick");
  a_even_off: assert property ((channel_waveform_output & even_mask) == 8'h00)
    else $error("even output of joined pair active");
  a_disabled_off: assert property ((channel_waveform_output & ~(en_r | en_q | en_q2)) == 8'h00)
    else $error("disabled channel drives output");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_enable_rdbk: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == en_q) else $error("enable readback");
  a_join_rdbk: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata[3:0] == join_q)
    else $error("join readback");
  a_cnt_clear: assert property (reg_wr && reg_addr == 8'h08 ##1 clk_tick == 4'h0 ##1 reg_rd && reg_addr == 8'h08
    |=> reg_rdata == 8'h00) else $error("counter not cleared");

  c_cnt_read: cover property (reg_rd && reg_addr == 8'h08);
  c_odd_rise: cover property ($rose(channel_waveform_output[1]));
  c_joined_run: cover property (join_r[0] && channel_waveform_output[1]);
endmodule // pwc_props

bind pwc_core pwc_props u_props (
  .clk_sys                 (clk_sys),
  .reset                   (reset),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata               (reg_rdata),
  .clk_tick                (clk_tick),
  .channel_waveform_output (channel_waveform_output)
);

// file: dv/pwc_core_tb_top.sv
// self-checking bench of the pwm channel core
`define CHECK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("ERROR %0t: got %0h want %0h", $time, got, exp); \
  end \
end

module pwc_core_tb_top import pwc_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic      al;
    logic      po;
    pwc_byte_t per;
    pwc_byte_t dty;
    pwc_byte_t hi;
    pwc_byte_t ri;
  } pwc_row_s;

  logic       clk_sys    = 1'b0;
  logic       reset      = 1'b1;
  pwc_byte_t  reg_addr   = 8'h00;
  pwc_byte_t  reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  logic [3:0] clk_tick   = 4'h0;
  pwc_byte_t  reg_rdata;
  pwc_byte_t  channel_waveform_output;
  int         err_count  = 0;
  int         num_checks = 0;
  // align, polarity, period, duty, high cycles and rising edges in 120 cycles
  pwc_row_s   rows [10]  = '{
    '{1'b0, 1'b0, 8'h04, 8'h01, 8'h5A, 8'h1E}, '{1'b0, 1'b1, 8'h04, 8'h01, 8'h1E, 8'h1E},
    '{1'b1, 1'b0, 8'h04, 8'h01, 8'h5A, 8'h0F}, '{1'b1, 1'b1, 8'h05, 8'h02, 8'h30, 8'h0C},
    '{1'b0, 1'b0, 8'h06, 8'h00, 8'h78, 8'h00}, '{1'b0, 1'b1, 8'h06, 8'h00, 8'h00, 8'h00},
    '{1'b0, 1'b1, 8'h00, 8'h02, 8'h78, 8'h00}, '{1'b0, 1'b0, 8'h00, 8'h02, 8'h00, 8'h00},
    '{1'b1, 1'b1, 8'h03, 8'h03, 8'h78, 8'h00}, '{1'b1, 1'b0, 8'h03, 8'h05, 8'h00, 8'h00}};
  // counter after each tick: left, center, period change while running
  pwc_byte_t  seq [3][10] = '{
    '{8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
    '{8'h01, 8'h02, 8'h03, 8'h02, 8'h01, 8'h00, 8'h01, 8'h02, 8'h03, 8'h02},
    '{8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00}};

  pwc_core i_dut (
    .clk_sys                 (clk_sys),
    .reset                   (reset),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .clk_tick                (clk_tick),
    .channel_waveform_output (channel_waveform_output)
  );

  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // one-cycle register write
  task automatic wr(input pwc_byte_t a, input pwc_byte_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // register read, data compared in the following cycle
  task automatic chk_rd(input pwc_byte_t a, input pwc_byte_t exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    `CHECK(reg_rdata, exp)
  endtask

  // n ticks of channel clock a
  task automatic tick(input int n);
    @(posedge clk_sys);
    clk_tick <= 4'h1;
    repeat (n) @(posedge clk_sys);
    clk_tick <= 4'h0;
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    pwc_byte_t hi;
    pwc_byte_t ri;
    logic      prev;
    repeat (4) @(posedge clk_sys);
    reset    <= 1'b0;
    chk_rd(8'h02, 8'hA0);
    clk_tick <= 4'h1;
    foreach (rows[i]) begin
      wr(8'h00, 8'h00);
      wr(8'h04, {7'h00, rows[i].al});
      wr(8'h01, {7'h00, rows[i].po});
      wr(8'h10, rows[i].per);
      wr(8'h18, rows[i].dty);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h01);
      repeat (20) @(posedge clk_sys);
      #1;
      hi   = 8'h00;
      ri   = 8'h00;
      prev = channel_waveform_output[0];
      repeat (120) begin
        @(posedge clk_sys);
        #1;
        hi   = hi + {7'h00, channel_waveform_output[0]};
        ri   = ri + {7'h00, channel_waveform_output[0] & ~prev};
        prev = channel_waveform_output[0];
      end
      `CHECK(hi, rows[i].hi)
      `CHECK(ri, rows[i].ri)
      if (rows[i].per === 8'h00) chk_rd(8'h08, 8'h00);
    end
    @(posedge clk_sys);
    clk_tick <= 4'h0;
    $display("waveform table done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, (m == 1) ? 8'h01 : 8'h00);
      wr(8'h10, (m == 2) ? 8'h04 : 8'h03);
      wr(8'h18, 8'h01);
      wr(8'h08, 8'h00);
      chk_rd(8'h08, 8'h00);
      wr(8'h00, 8'h01);
      if (m == 2) wr(8'h10, 8'h06);
      for (int k = 0; k < 10; k++) begin
        tick(1);
        chk_rd(8'h08, seq[m][k]);
      end
    end
    chk_rd(8'h06, 8'h00);
    $display("counter steps done");
    wr(8'h00, 8'h00);
    wr(8'h05, 8'h01);
    chk_rd(8'h05, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h11, 8'h02);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h00);
    wr(8'h09, 8'h00);
    wr(8'h00, 8'h03);
    tick(257);
    chk_rd(8'h08, 8'h01);
    chk_rd(8'h09, 8'h01);
    `CHECK(channel_waveform_output[1:0], 2'h2)
    wr(8'h09, 8'h00);
    chk_rd(8'h08, 8'h00);
    $display("joined pair done");
    complete_run();
  end

  // watchdog well beyond the expected run of about 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end
endmodule // pwc_core_tb_top
